// [hw/mic_pkg.sv]
// package: register map, field positions, vectors and codes of the interrupt controller
package mic_pkg;
    // register offsets on the plain register port (chosen map)
    localparam logic [2:0] ADDR_FLAG_ENABLE_A = 3'h0;
    localparam logic [2:0] ADDR_FLAG_ENABLE_B = 3'h1;
    localparam logic [2:0] ADDR_PIN_EDGE_SELECT = 3'h2;
    localparam logic [2:0] ADDR_PRESCALER_SOURCE = 3'h3;
    localparam logic [2:0] ADDR_TICK_PERIOD_CTRL = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    // first register fields
    localparam int A_TIMER_FLAG = 6;
    localparam int A_TOUCH_FLAG = 5;
    localparam int A_PIN_FLAG = 4;
    localparam int A_TIMER_ON = 3;
    localparam int A_TOUCH_ON = 2;
    localparam int A_PIN_ON = 1;
    localparam int A_GLOBAL_ON = 0;
    // second register fields
    localparam int B_TICK_FLAG = 5;
    localparam int B_OVERVOLT_FLAG = 4;
    localparam int B_TICK_ON = 1;
    localparam int B_OVERVOLT_ON = 0;
    // tick control fields
    localparam int TICK_ON_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] A_WRITE_MASK = 8'h7f;
    localparam logic [7:0] B_WRITE_MASK = 8'h33;
    localparam logic [7:0] TICK_WRITE_MASK = 8'h87;
    // source indices, highest priority first
    localparam int SRC_PIN = 0;
    localparam int SRC_TOUCH = 1;
    localparam int SRC_TIMER = 2;
    localparam int SRC_OVERVOLT = 3;
    localparam int SRC_TICK = 4;
    localparam int NUM_SRC = 5;
    // vector addresses, one per source
    localparam logic [10:0] VEC_PIN = 11'h004;
    localparam logic [10:0] VEC_TOUCH = 11'h008;
    localparam logic [10:0] VEC_TIMER = 11'h00c;
    localparam logic [10:0] VEC_OVERVOLT = 11'h010;
    localparam logic [10:0] VEC_TICK = 11'h014;
    // pin edge modes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // prescaler sources
    localparam logic [1:0] PSC_SYS = 2'h0;
    localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
    localparam int TICK_MIN_EXP = 8;
    localparam int TICK_DIV_WIDTH = 16;
    localparam int PC_WIDTH = 11;
    // service sequencer states
    typedef enum logic [1:0] {
        SEQ_RUN = 2'b01,
        SEQ_TAKE = 2'b10
    } mic_seq_e;
endpackage

// [hw/mic_interrupt_controller.sv]
// interrupt controller: flags, enables, pin edge detect, tick divider, vectoring to the core
//
// Behaviour
// - first register: timer, touch, pin flags, three enables, global
// - second register: tick, overvolt flags and enables
// - events set flag; vector only if enabled
// - disabled source sets flag, no vector
// - global off blocks every interrupt
// - take: push return pc, load vector
// - return-from-irq pops pc and resumes
// - servicing clears global enable; nesting only if software sets it again
// - requests during service keep their flags
// - stack full blocks acknowledgement
// - simultaneous requests use fixed priority
// - any flag rising wakes from sleep
// - pin flag set on selected edge
// - edge mode: off, rise, fall, both
// - pin input only when enabled and input
// - servicing clears the source's own flag
// - touch slot overflow sets touch flag
// - timer overflow sets timer flag
// - overvoltage detect sets overvolt flag
// - tick flag set on time base overflow
// - prescaler source: sys, sys/4, sub clock
// - tick period 2^8..2^15, tick on enables
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_controller (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic pin_in,
    input wire logic pin_is_input,
    input wire logic touch_overflow,
    input wire logic timer_overflow,
    input wire logic overvolt_detect,
    input wire logic sub_clock,
    input wire logic [10:0] core_next_pc,
    input wire logic core_stack_full,
    input wire logic core_take_ok,
    input wire logic return_from_irq,
    output logic irq_take,
    output logic [10:0] irq_vector,
    output logic [10:0] irq_push_pc,
    output logic irq_wake
);
    logic [7:0] a_reg, a_next;
    logic [7:0] b_reg, b_next;
    logic [1:0] pin_edge_mode_reg, pin_edge_mode_next;
    logic [1:0] prescaler_source_reg, prescaler_source_next;
    logic [7:0] tick_period_ctrl_reg, tick_period_ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic sub_s1_reg, sub_s2_reg, sub_s3_reg;
    logic [1:0] div4_reg, div4_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic tick_pulse_reg, tick_pulse_next;
    mic_pkg::mic_seq_e seq_reg, seq_next;
    logic take_reg, take_next;
    logic [10:0] vec_reg, vec_next;
    logic [10:0] push_reg, push_next;
    logic wake_reg, wake_next;
    logic [4:0] flags, enables, events, pending, grant;
    logic pin_edge, psc_tick, any_req;

    // lowest set bit wins: bit 0 is the highest priority source
    function automatic logic [4:0] pick_first(input logic [4:0] req);
        logic [4:0] g;
        g = 5'h00;
        for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                g = 5'h00;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    function automatic logic [10:0] vector_of(input logic [4:0] g);
        logic [10:0] v;
        v = mic_pkg::VEC_TICK;
        if (g[mic_pkg::SRC_PIN]) v = mic_pkg::VEC_PIN;
        else if (g[mic_pkg::SRC_TOUCH]) v = mic_pkg::VEC_TOUCH;
        else if (g[mic_pkg::SRC_TIMER]) v = mic_pkg::VEC_TIMER;
        else if (g[mic_pkg::SRC_OVERVOLT]) v = mic_pkg::VEC_OVERVOLT;
        return v;
    endfunction

    // pin and sub clock come from outside: two flops before any logic, third for the edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            sub_s1_reg <= sub_clock;
            sub_s2_reg <= sub_s1_reg;
            sub_s3_reg <= sub_s2_reg;
        end
    end

    // edge decode; the pin only counts while enabled and set as input
    always_comb begin
        unique case (pin_edge_mode_reg)
            mic_pkg::EDGE_RISE: pin_edge = pin_s2_reg & ~pin_s3_reg;
            mic_pkg::EDGE_FALL: pin_edge = ~pin_s2_reg & pin_s3_reg;
            mic_pkg::EDGE_BOTH: pin_edge = pin_s2_reg ^ pin_s3_reg;
            default: pin_edge = 1'b0;
        endcase
        pin_edge = pin_edge & a_reg[mic_pkg::A_PIN_ON] & pin_is_input;
    end

    // prescaler source pulse and tick divider
    always_comb begin
        div4_next = div4_reg + 2'h1;
        if (prescaler_source_reg == mic_pkg::PSC_SYS) psc_tick = 1'b1;
        else if (prescaler_source_reg == mic_pkg::PSC_SYS_DIV4) psc_tick = (div4_reg == 2'h3);
        else psc_tick = sub_s2_reg & ~sub_s3_reg;
        tick_cnt_next = tick_cnt_reg;
        tick_pulse_next = 1'b0;
        if (!tick_period_ctrl_reg[mic_pkg::TICK_ON_BIT]) begin
            tick_cnt_next = 16'h0000;
        end else if (psc_tick) begin
            tick_cnt_next = tick_cnt_reg + 16'h0001;
            // overflow of bit (8 + sel - 1) marks the chosen period
            if (tick_cnt_next[mic_pkg::TICK_MIN_EXP - 1 + int'(tick_period_ctrl_reg[2:0])] == 1'b0 &&
                tick_cnt_reg[mic_pkg::TICK_MIN_EXP - 1 + int'(tick_period_ctrl_reg[2:0])] == 1'b1) begin
                tick_pulse_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div4_reg <= 2'h0;
            tick_cnt_reg <= 16'h0000;
            tick_pulse_reg <= 1'b0;
        end else begin
            div4_reg <= div4_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_pulse_reg <= tick_pulse_next;
        end
    end

    // pin and tick pulses reach their flags one edge later
    a_pin_sets: assert property (@(posedge clock) disable iff (!rst_n)
        pin_edge |=> a_reg[mic_pkg::A_PIN_FLAG])
        else $error("pin edge lost");

    // a pin that is not an enabled input never raises the flag
    a_pin_input: assert property (@(posedge clock) disable iff (!rst_n)
        !pin_is_input || !a_reg[mic_pkg::A_PIN_ON] |-> !pin_edge)
        else $error("pin edge while not an enabled input");

    a_tick_sets: assert property (@(posedge clock) disable iff (!rst_n)
        tick_pulse_reg |=> b_reg[mic_pkg::B_TICK_FLAG])
        else $error("tick pulse lost");

    // tick off restarts the period from zero
    a_tick_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        !tick_period_ctrl_reg[mic_pkg::TICK_ON_BIT] |=> tick_cnt_reg == 16'h0000 && !tick_pulse_reg)
        else $error("tick divider ran while off");

    assign flags = {b_reg[mic_pkg::B_TICK_FLAG], b_reg[mic_pkg::B_OVERVOLT_FLAG], a_reg[mic_pkg::A_TIMER_FLAG],
                    a_reg[mic_pkg::A_TOUCH_FLAG], a_reg[mic_pkg::A_PIN_FLAG]};
    assign enables = {b_reg[mic_pkg::B_TICK_ON], b_reg[mic_pkg::B_OVERVOLT_ON], a_reg[mic_pkg::A_TIMER_ON],
                      a_reg[mic_pkg::A_TOUCH_ON], a_reg[mic_pkg::A_PIN_ON]};
    assign events = {tick_pulse_reg, overvolt_detect, timer_overflow, touch_overflow, pin_edge};
    assign pending = flags & enables;
    assign any_req = (|pending) & a_reg[mic_pkg::A_GLOBAL_ON] & ~core_stack_full;
    assign grant = pick_first(pending);

    // service sequencer: one take pulse, then back to run on the next edge
    always_comb begin
        seq_next = seq_reg;
        take_next = 1'b0;
        vec_next = vec_reg;
        push_next = push_reg;
        unique case (seq_reg)
            mic_pkg::SEQ_RUN: begin
                if (any_req && core_take_ok) begin
                    seq_next = mic_pkg::SEQ_TAKE;
                    take_next = 1'b1;
                    vec_next = vector_of(grant);
                    push_next = core_next_pc;
                end
            end
            mic_pkg::SEQ_TAKE: seq_next = mic_pkg::SEQ_RUN;
        endcase
    end

    // register file: event set wins over software clear
    always_comb begin
        logic [4:0] f;
        logic [4:0] clr;
        f = flags;
        clr = (seq_reg == mic_pkg::SEQ_RUN && any_req && core_take_ok) ? grant : 5'h00;
        a_next = a_reg;
        b_next = b_reg;
        pin_edge_mode_next = pin_edge_mode_reg;
        prescaler_source_next = prescaler_source_reg;
        tick_period_ctrl_next = tick_period_ctrl_reg;
        if (reg_write) begin
            unique case (reg_addr)
                mic_pkg::ADDR_FLAG_ENABLE_A: begin
                    a_next = reg_wdata & mic_pkg::A_WRITE_MASK;
                    f[mic_pkg::SRC_PIN] = reg_wdata[mic_pkg::A_PIN_FLAG];
                    f[mic_pkg::SRC_TOUCH] = reg_wdata[mic_pkg::A_TOUCH_FLAG];
                    f[mic_pkg::SRC_TIMER] = reg_wdata[mic_pkg::A_TIMER_FLAG];
                end
                mic_pkg::ADDR_FLAG_ENABLE_B: begin
                    b_next = reg_wdata & mic_pkg::B_WRITE_MASK;
                    f[mic_pkg::SRC_OVERVOLT] = reg_wdata[mic_pkg::B_OVERVOLT_FLAG];
                    f[mic_pkg::SRC_TICK] = reg_wdata[mic_pkg::B_TICK_FLAG];
                end
                mic_pkg::ADDR_PIN_EDGE_SELECT: pin_edge_mode_next = reg_wdata[1:0];
                mic_pkg::ADDR_PRESCALER_SOURCE: prescaler_source_next = reg_wdata[1:0];
                mic_pkg::ADDR_TICK_PERIOD_CTRL: tick_period_ctrl_next = reg_wdata & mic_pkg::TICK_WRITE_MASK;
                default: ;
            endcase
        end
        f = (f & ~clr) | events;
        if (clr != 5'h00) a_next[mic_pkg::A_GLOBAL_ON] = 1'b0;
        else if (return_from_irq) a_next[mic_pkg::A_GLOBAL_ON] = 1'b1;
        a_next[mic_pkg::A_PIN_FLAG] = f[mic_pkg::SRC_PIN];
        a_next[mic_pkg::A_TOUCH_FLAG] = f[mic_pkg::SRC_TOUCH];
        a_next[mic_pkg::A_TIMER_FLAG] = f[mic_pkg::SRC_TIMER];
        b_next[mic_pkg::B_OVERVOLT_FLAG] = f[mic_pkg::SRC_OVERVOLT];
        b_next[mic_pkg::B_TICK_FLAG] = f[mic_pkg::SRC_TICK];
        wake_next = |(events & ~flags);
        rdata_next = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                mic_pkg::ADDR_FLAG_ENABLE_A: rdata_next = a_reg;
                mic_pkg::ADDR_FLAG_ENABLE_B: rdata_next = b_reg;
                mic_pkg::ADDR_PIN_EDGE_SELECT: rdata_next = {6'h00, pin_edge_mode_reg};
                mic_pkg::ADDR_PRESCALER_SOURCE: rdata_next = {6'h00, prescaler_source_reg};
                mic_pkg::ADDR_TICK_PERIOD_CTRL: rdata_next = tick_period_ctrl_reg;
                mic_pkg::ADDR_STATUS: rdata_next = {2'h0, seq_reg == mic_pkg::SEQ_TAKE, grant};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            a_reg <= mic_pkg::RESET_BYTE;
            b_reg <= mic_pkg::RESET_BYTE;
            pin_edge_mode_reg <= 2'h0;
            prescaler_source_reg <= 2'h0;
            tick_period_ctrl_reg <= mic_pkg::RESET_BYTE;
            rdata_reg <= 8'h00;
            seq_reg <= mic_pkg::SEQ_RUN;
            take_reg <= 1'b0;
            vec_reg <= 11'h000;
            push_reg <= 11'h000;
            wake_reg <= 1'b0;
        end else begin
            a_reg <= a_next;
            b_reg <= b_next;
            pin_edge_mode_reg <= pin_edge_mode_next;
            prescaler_source_reg <= prescaler_source_next;
            tick_period_ctrl_reg <= tick_period_ctrl_next;
            rdata_reg <= rdata_next;
            seq_reg <= seq_next;
            take_reg <= take_next;
            vec_reg <= vec_next;
            push_reg <= push_next;
            wake_reg <= wake_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq_take = take_reg;
    assign irq_vector = vec_reg;
    assign irq_push_pc = push_reg;
    assign irq_wake = wake_reg;

    // take needs global enable one cycle earlier, and clears it
    a_take_global: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(irq_take) |-> $past(a_reg[mic_pkg::A_GLOBAL_ON]) && !a_reg[mic_pkg::A_GLOBAL_ON])
        else $error("interrupt taken without global enable");
    a_take_stack: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take |-> !$past(core_stack_full))
        else $error("interrupt taken with full stack");
    a_take_enabled: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take |-> |($past(pending)))
        else $error("interrupt taken with nothing enabled pending");
    a_take_single: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take |=> !irq_take)
        else $error("two takes back to back");
    a_pin_vector: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take && $past(pending[mic_pkg::SRC_PIN]) |-> irq_vector == mic_pkg::VEC_PIN)
        else $error("pin not given top priority");
    a_push_pc: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take |-> irq_push_pc == $past(core_next_pc))
        else $error("pushed pc mismatch");
    a_event_sets: assert property (@(posedge clock) disable iff (!rst_n)
        timer_overflow |=> a_reg[mic_pkg::A_TIMER_FLAG])
        else $error("timer overflow lost");
    a_return_from_irq_global: assert property (@(posedge clock) disable iff (!rst_n)
        return_from_irq && !any_req |=> a_reg[mic_pkg::A_GLOBAL_ON])
        else $error("return did not re-enable");
    a_wake_rise: assert property (@(posedge clock) disable iff (!rst_n)
        irq_wake |-> |(flags & ~$past(flags)))
        else $error("wake without a rising flag");
    a_pin_off: assert property (@(posedge clock) disable iff (!rst_n)
        pin_edge_mode_reg == mic_pkg::EDGE_OFF |-> !pin_edge)
        else $error("pin edge while disabled");

    // every outside event lands in its own flag
    a_touch_sets: assert property (@(posedge clock) disable iff (!rst_n)
        touch_overflow |=> a_reg[mic_pkg::A_TOUCH_FLAG])
        else $error("touch overflow lost");

    a_overvolt_sets: assert property (@(posedge clock) disable iff (!rst_n)
        overvolt_detect |=> b_reg[mic_pkg::B_OVERVOLT_FLAG])
        else $error("overvoltage detect lost");

    // a rising flag wakes whatever the enables hold
    a_wake_event: assert property (@(posedge clock) disable iff (!rst_n)
        |(events & ~flags) |=> irq_wake)
        else $error("rising flag gave no wake");

    // with global off nothing is taken next cycle
    a_global_blocks: assert property (@(posedge clock) disable iff (!rst_n)
        !a_reg[mic_pkg::A_GLOBAL_ON] |=> !irq_take)
        else $error("take while global off");

    a_tick_enabled: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take && irq_vector == mic_pkg::VEC_TICK |-> $past(b_reg[mic_pkg::B_TICK_ON]))
        else $error("tick vector without tick enable");

    a_touch_priority: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take && $past(pending[mic_pkg::SRC_TOUCH]) && !$past(pending[mic_pkg::SRC_PIN]) |->
        irq_vector == mic_pkg::VEC_TOUCH)
        else $error("touch not served first");

    // service clears the granted flag unless an event hits the same edge
    a_timer_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        irq_take && irq_vector == mic_pkg::VEC_TIMER && !$past(timer_overflow) |->
        !a_reg[mic_pkg::A_TIMER_FLAG])
        else $error("timer flag kept after service");

    // blocked requests stay until software writes the register
    a_flag_kept: assert property (@(posedge clock) disable iff (!rst_n)
        a_reg[mic_pkg::A_TOUCH_FLAG] && !a_reg[mic_pkg::A_GLOBAL_ON] &&
        !(reg_write && reg_addr == mic_pkg::ADDR_FLAG_ENABLE_A) |=> a_reg[mic_pkg::A_TOUCH_FLAG])
        else $error("blocked touch request dropped");

    // unused bits read back as zero
    a_first_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr == mic_pkg::ADDR_FLAG_ENABLE_A |=> !reg_rdata[7])
        else $error("reserved bit of first register set");

    a_second_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr == mic_pkg::ADDR_FLAG_ENABLE_B |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0)
        else $error("reserved bits of second register set");

    c_take_pin: cover property (@(posedge clock) disable iff (!rst_n) irq_take && irq_vector == mic_pkg::VEC_PIN);
    c_take_tick: cover property (@(posedge clock) disable iff (!rst_n) irq_take && irq_vector == mic_pkg::VEC_TICK);
    c_full_block: cover property (@(posedge clock) disable iff (!rst_n) |pending && core_stack_full);
    c_wake: cover property (@(posedge clock) disable iff (!rst_n) irq_wake);
    c_nested: cover property (@(posedge clock) disable iff (!rst_n) irq_take && irq_push_pc == mic_pkg::VEC_TIMER);
endmodule // mic_interrupt_controller
`default_nettype wire

// [verif/mic_core_model.sv]
// core stand-in: program counter, return stack and return-from-irq pulse
`timescale 1ns/1ps
`default_nettype none
module mic_core_model #(
    parameter int DEPTH = 4,
    parameter logic [10:0] MAIN_PC = 11'h123
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic irq_take,
    input wire logic [10:0] irq_vector,
    input wire logic [10:0] irq_push_pc,
    input wire logic full_req,
    input wire logic ret_req,
    output logic [10:0] core_next_pc,
    output logic core_stack_full,
    output logic core_take_ok,
    output logic return_from_irq
);
    logic [10:0] stack [DEPTH];
    int used;
    // pc parks on one address so that every push can be predicted
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_next_pc <= MAIN_PC;
            return_from_irq <= 1'b0;
            used <= 0;
        end else begin
            return_from_irq <= ret_req;
            if (irq_take) begin
                stack[used] <= irq_push_pc;
                core_next_pc <= irq_vector;
                used <= used + 1;
            end else if (ret_req && used > 0) begin
                core_next_pc <= stack[used - 1];
                used <= used - 1;
            end
        end
    end
    // a forced full lets the bench hold off acceptance without deep nesting
    assign core_stack_full = full_req || (used >= DEPTH);
    assign core_take_ok = rst_n;
endmodule // mic_core_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench: register port, events, vectoring, priority, pin edges, tick divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic pin_in = 1'b0;
    logic pin_is_input = 1'b1;
    logic [2:0] ev = 3'h0; // touch, timer, overvolt
    logic sub_clock = 1'b0;
    logic full_req = 1'b0;
    logic ret_req = 1'b0;
    logic [10:0] core_next_pc, irq_vector, irq_push_pc;
    logic core_stack_full, core_take_ok, return_from_irq, irq_take, irq_wake;
    int bad_count = 0;
    int samples_checked = 0;
    int takes = 0;
    int wakes = 0;
    int t0;
    int w0;
    logic [10:0] vec_tab [5] = '{mic_pkg::VEC_PIN, mic_pkg::VEC_TOUCH, mic_pkg::VEC_TIMER,
        mic_pkg::VEC_OVERVOLT, mic_pkg::VEC_TICK};
    logic [7:0] wexp [5] = '{8'h7e, 8'h33, 8'h03, 8'h03, 8'h87};
    logic [7:0] tk_src [4] = '{8'h00, 8'h01, 8'h02, 8'h00};
    logic [7:0] tk_sel [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
    int tk_len [4] = '{256, 1024, 1792, 512}; // sub clock rises every 7 cycles

    mic_interrupt_controller DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_is_input(pin_is_input), .touch_overflow(ev[0]), .timer_overflow(ev[1]),
        .overvolt_detect(ev[2]), .sub_clock(sub_clock), .core_next_pc(core_next_pc),
        .core_stack_full(core_stack_full), .core_take_ok(core_take_ok), .return_from_irq(return_from_irq),
        .irq_take(irq_take), .irq_vector(irq_vector), .irq_push_pc(irq_push_pc), .irq_wake(irq_wake));
    mic_core_model core (.clock(clock), .rst_n(rst_n), .irq_take(irq_take), .irq_vector(irq_vector),
        .irq_push_pc(irq_push_pc), .full_req(full_req), .ret_req(ret_req), .core_next_pc(core_next_pc),
        .core_stack_full(core_stack_full), .core_take_ok(core_take_ok), .return_from_irq(return_from_irq));

    // clocks: system 10 ns, sub clock unrelated at 70 ns
    initial forever #5 clock = ~clock;
    initial #2 forever #35 sub_clock = ~sub_clock;

    // counting every high cycle also catches a take or wake that lingers
    always @(posedge clock) begin
        if (irq_take === 1'b1) takes <= takes + 1;
        if (irq_wake === 1'b1) wakes <= wakes + 1;
    end

    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata", {3'h0, reg_rdata}, {3'h0, exp});
    endtask

    task automatic ev_pulse(input logic [2:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 3'h0;
    endtask

    task automatic wait_take(input logic [10:0] exp);
        t0 = takes;
        for (int i = 0; i < 20 && takes == t0; i++) @(posedge clock);
        #1;
        chk("irq_take count", 11'(takes - t0), 11'h001);
        chk("irq_vector", irq_vector, exp);
        chk("irq_push_pc", irq_push_pc, 11'h123);
    endtask

    // pc is checked right after the pop, before a pending take moves it
    task automatic ret_pulse(input logic [10:0] exp);
        @(posedge clock);
        ret_req <= 1'b1;
        @(posedge clock);
        ret_req <= 1'b0;
        #1;
        chk("core_next_pc", core_next_pc, exp);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) rd(3'(a), 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        for (int a = 0; a < 5; a++) begin
            wr(3'(a), (a == 0) ? 8'hfe : 8'hff);
            rd(3'(a), wexp[a]);
            wr(3'(a), 8'h00);
        end
        w0 = wakes;
        ev_pulse(3'b001);
        ev_pulse(3'b010);
        ev_pulse(3'b100);
        ev_pulse(3'b010);
        rd(3'h0, 8'h60);
        rd(3'h1, 8'h10);
        chk("irq_wake count", 11'(wakes - w0), 11'h003);
        chk("irq_take count", 11'(takes), 11'h000);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h48);
        repeat (10) @(posedge clock);
        chk("irq_take count", 11'(takes), 11'h000);
        full_req <= 1'b1;
        wr(3'h0, 8'h49);
        repeat (10) @(posedge clock);
        chk("irq_take count", 11'(takes), 11'h000);
        full_req <= 1'b0;
        wait_take(mic_pkg::VEC_TIMER);
        rd(3'h0, 8'h08);
        wr(3'h0, 8'h1b);
        repeat (4) @(posedge clock);
        chk("irq_vector", irq_vector, mic_pkg::VEC_PIN);
        chk("irq_push_pc", irq_push_pc, mic_pkg::VEC_TIMER);
        ret_pulse(mic_pkg::VEC_TIMER);
        ret_pulse(11'h123);
        rd(3'h0, 8'h0b);
        wr(3'h0, 8'h7e);
        wr(3'h1, 8'h33);
        wr(3'h0, 8'h7f);
        for (int s = 0; s < 5; s++) begin
            wait_take(vec_tab[s]);
            repeat (10) @(posedge clock);
            chk("irq_take count", 11'(takes - t0), 11'h001);
            ret_pulse(11'h123);
        end
        rd(3'h0, 8'h0f);
        rd(3'h1, 8'h03);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(3'h2, 8'(m));
            wr(3'h0, 8'h02);
            pin_in <= 1'b1;
            repeat (8) @(posedge clock);
            rd(3'h0, {3'h0, m[0], 4'h2});
            wr(3'h0, 8'h02);
            pin_in <= 1'b0;
            repeat (8) @(posedge clock);
            rd(3'h0, {3'h0, m[1], 4'h2});
        end
        wr(3'h0, 8'h02);
        pin_is_input <= 1'b0;
        pin_in <= 1'b1;
        repeat (8) @(posedge clock);
        rd(3'h0, 8'h02);
        wr(3'h0, 8'h00);
        pin_is_input <= 1'b1;
        pin_in <= 1'b0;
        repeat (8) @(posedge clock);
        rd(3'h0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(3'h3, tk_src[k]);
            wr(3'h1, 8'h00);
            wr(3'h4, 8'h80 | tk_sel[k]);
            repeat (tk_len[k] * 3 / 4) @(posedge clock);
            rd(3'h1, 8'h00);
            repeat (tk_len[k] / 2) @(posedge clock);
            rd(3'h1, 8'h20);
            wr(3'h4, 8'h00);
        end
        complete_run();
    end

    // watchdog: the sequence needs well under 10000 cycles
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
